/* File: design/sfcr_pkg.sv */
// Shared constants for the serial flash continuous read link
package sfcr_pkg;
	localparam logic [7:0]  OPC_LEGACY     = 8'he8;
	localparam logic [7:0]  OPC_TOP        = 8'h1b;
	localparam logic [7:0]  OPC_FAST       = 8'h0b;
	localparam logic [2:0]  DUMMY_LEGACY   = 3'h4;
	localparam logic [2:0]  DUMMY_TOP      = 3'h2;
	localparam logic [2:0]  DUMMY_FAST     = 3'h1;
	localparam int          ADDR_BYTES     = 3;
	localparam int          PAGE_BITS      = 13;
	localparam int          BYTE_BITS_528  = 10;
	localparam int          BYTE_BITS_512  = 9;
	localparam logic [9:0]  PAGE_LAST_528  = 10'h20f;
	localparam logic [9:0]  PAGE_LAST_512  = 10'h1ff;
	localparam logic [12:0] PAGE_LAST      = 13'h1fff;
	localparam int          MEM_ADDR_W     = 23;
	localparam int          CLK_DIV_HALF   = 4;
	localparam logic [2:0]  BIT_LAST       = 3'h7;
endpackage : sfcr_pkg

/* File: design/sfcr_link_if.sv */
// Serial link between host controller and flash device
`timescale 1ns/100ps
interface sfcr_link_if;
	logic cs_b;
	logic sck;
	logic si;
	logic so_out;
	logic so_oe;
	logic so;
	// No tristate in this model: a released line reads as its pull-up
	assign so = so_oe ? so_out : 1'b1;
	modport host_mp (output cs_b, output sck, output si, input so);
	modport dev_mp (input cs_b, input sck, input si, output so_out, output so_oe);
endinterface : sfcr_link_if

/* File: design/sfcr_device.sv */
// Flash device end: command decode, address split, continuous array stream
// Contract
// - E8h: three address, four dummy bytes
// - 1Bh: three address, two dummy bytes
// - 0Bh: three address, one dummy byte
// - 528 page: 13 page, 10 byte bits
// - 512 page: 13 page, 9 byte bits
// - Internal address counter advances with output
// - Data driven each clock after dummies
// - Host holds select low whole transfer
// - Page end continues next page, no gap
// - Array end wraps to first page
// - Select rise ends read, output released
// - Array read leaves buffers untouched
// - Host keeps clock within read limit
// - Legacy opcode not for new hosts
// - All bits shifted most significant first
// - Command starts at select falling edge
// - SPI modes 0 and 3 supported
`timescale 1ns/100ps
module sfcr_device #(
	parameter int MEM_WORDS = 8192 * 528
) (
	input  wire logic core_clk,
	input  wire logic rst_b,
	sfcr_link_if.dev_mp link,
	input  wire logic page_512,
	input  wire logic [7:0] mem_rdata,
	output logic [sfcr_pkg::MEM_ADDR_W-1:0] mem_addr,
	output logic busy
);
	import sfcr_pkg::*;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_OPC   = 5'b00010,
		ST_ADDR  = 5'b00100,
		ST_DUMMY = 5'b01000,
		ST_DATA  = 5'b10000
	} sfcr_dst_t;

	typedef struct packed {
		logic [1:0]  cs_sync;
		logic [1:0]  sck_sync;
		logic [1:0]  si_sync;
		logic        cs_q;
		logic        sck_q;
		sfcr_dst_t   st;
		logic [2:0]  bitc;
		logic [1:0]  bytec;
		logic [2:0]  dummy_n;
		logic [7:0]  sh;
		logic [23:0] addr_raw;
		logic [12:0] page;
		logic [9:0]  col;
		logic [7:0]  dout;
		logic        so_bit;
		logic        so_oe;
	} sfcr_dev_t;

	sfcr_dev_t s, next_s;

	logic cs_b_s, sck_s, si_s, sck_rise, sck_fall, cs_rise, cs_fall;

	// Byte count of dummy phase for an opcode; zero means unsupported
	function automatic logic [2:0] dummy_count(input logic [7:0] opc);
		if (opc == OPC_LEGACY) begin
			return DUMMY_LEGACY;
		end else if (opc == OPC_TOP) begin
			return DUMMY_TOP;
		end else if (opc == OPC_FAST) begin
			return DUMMY_FAST;
		end else begin
			return 3'h0;
		end
	endfunction : dummy_count

	always_comb begin
		cs_b_s   = s.cs_sync[1];
		sck_s    = s.sck_sync[1];
		si_s     = s.si_sync[1];
		sck_rise = sck_s & ~s.sck_q;
		sck_fall = ~sck_s & s.sck_q;
		cs_rise  = cs_b_s & ~s.cs_q;
		cs_fall  = ~cs_b_s & s.cs_q;
	end

	always_comb begin
		logic [7:0]  sh_in;
		logic [9:0]  col_last;
		sh_in    = {s.sh[6:0], si_s};
		col_last = page_512 ? PAGE_LAST_512 : PAGE_LAST_528;
		next_s   = s;
		next_s.cs_sync  = {s.cs_sync[0], link.cs_b};
		next_s.sck_sync = {s.sck_sync[0], link.sck};
		next_s.si_sync  = {s.si_sync[0], link.si};
		next_s.cs_q     = cs_b_s;
		next_s.sck_q    = sck_s;
		if (cs_b_s) begin
			// Any rise mid-command drops back to idle
			next_s.st     = ST_IDLE;
			next_s.so_oe  = 1'b0;
			if (cs_rise) begin
				next_s.bitc = 3'h0;
			end
		end else if (cs_fall) begin
			next_s.st    = ST_OPC;
			next_s.bitc  = 3'h0;
			next_s.bytec = 2'h0;
			// Mode 3 idles high; first rise still follows the fall
		end else begin
			case (s.st)
				ST_OPC: begin
					if (sck_rise) begin
						next_s.sh   = sh_in;
						next_s.bitc = s.bitc + 3'h1;
						if (s.bitc == BIT_LAST) begin
							next_s.dummy_n = dummy_count(sh_in);
							next_s.st = (dummy_count(sh_in) == 3'h0) ? ST_IDLE : ST_ADDR;
						end
					end
				end
				ST_ADDR: begin
					if (sck_rise) begin
						next_s.addr_raw = {s.addr_raw[22:0], si_s};
						next_s.bitc     = s.bitc + 3'h1;
						if (s.bitc == BIT_LAST) begin
							next_s.bytec = s.bytec + 2'h1;
							if (s.bytec == 2'(ADDR_BYTES - 1)) begin
								next_s.st    = ST_DUMMY;
								next_s.bytec = 2'h0;
								if (page_512) begin
									next_s.page = s.addr_raw[20:8];
									next_s.col  = {1'b0, s.addr_raw[7:0], si_s};
								end else begin
									next_s.page = s.addr_raw[21:9];
									next_s.col  = {s.addr_raw[8:0], si_s};
								end
							end
						end
					end
				end
				ST_DUMMY: begin
					// Dummy bits are counted, never stored
					if (sck_rise) begin
						next_s.bitc = s.bitc + 3'h1;
						if (s.bitc == BIT_LAST) begin
							next_s.dummy_n = s.dummy_n - 3'h1;
							if (s.dummy_n == 3'h1) begin
								next_s.st   = ST_DATA;
								next_s.dout = mem_rdata;
							end
						end
					end
				end
				ST_DATA: begin
					// Shift on falling edge so host samples on rising
					if (sck_fall) begin
						next_s.so_oe  = 1'b1;
						next_s.so_bit = s.dout[3'h7 - s.bitc];
						next_s.bitc   = s.bitc + 3'h1;
						if (s.bitc == BIT_LAST) begin
							next_s.dout = mem_rdata;
						end
						// Step early so the next byte settles before bit 7 loads it
						if (s.bitc == 3'h0) begin
							if (s.col == col_last) begin
								next_s.col  = 10'h0;
								next_s.page = (s.page == PAGE_LAST) ? 13'h0 : s.page + 13'h1;
							end else begin
								next_s.col = s.col + 10'h1;
							end
						end
					end
				end
				default: begin
					next_s.st = ST_IDLE;
				end
			endcase
		end
		if (!rst_b) begin
			next_s       = '0;
			next_s.st    = ST_IDLE;
			next_s.cs_sync  = 2'b11;
			next_s.cs_q  = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		s <= next_s;
	end

	// Array only; buffers are never addressed by this path
	always_comb begin
		if (page_512) begin
			mem_addr = {1'b0, s.page, s.col[8:0]};
		end else begin
			mem_addr = {s.page, s.col};
		end
	end

	assign link.so_out = s.so_bit;
	assign link.so_oe  = s.so_oe;
	assign busy        = (s.st != ST_IDLE);
endmodule : sfcr_device

/* File: design/sfcr_host.sv */
// Host controller end: issues a continuous read and streams bytes back
`timescale 1ns/100ps
module sfcr_host (
	input  wire logic core_clk,
	input  wire logic rst_b,
	sfcr_link_if.host_mp link,
	input  wire logic start,
	input  wire logic [7:0] opcode,
	input  wire logic [23:0] addr,
	input  wire logic stop,
	output logic busy,
	output logic [7:0] rd_data,
	output logic rd_valid
);
	import sfcr_pkg::*;

	typedef enum logic [2:0] {
		HS_IDLE = 3'b001,
		HS_XFER = 3'b010,
		HS_END  = 3'b100
	} sfcr_hst_t;

	typedef struct packed {
		sfcr_hst_t   st;
		logic [1:0]  so_sync;
		logic [2:0]  div;
		logic        sck;
		logic        cs_b;
		logic [63:0] tx;
		logic [6:0]  hdr_bits;
		logic [2:0]  bitc;
		logic [7:0]  rx;
		logic [7:0]  rd_data;
		logic        rd_valid;
		logic        stop_req;
	} sfcr_host_st_t;

	sfcr_host_st_t s, next_s;

	always_comb begin
		logic [2:0] nd;
		nd     = 3'h0;
		next_s = s;
		next_s.so_sync  = {s.so_sync[0], link.so};
		next_s.rd_valid = 1'b0;
		next_s.stop_req = s.stop_req | stop;
		case (s.st)
			HS_IDLE: begin
				next_s.sck = 1'b0;
				next_s.stop_req = 1'b0;
				if (start) begin
					// E8h is legacy; prefer 1Bh or 0Bh on new systems
					if (opcode == OPC_LEGACY) begin
						nd = DUMMY_LEGACY;
					end else if (opcode == OPC_TOP) begin
						nd = DUMMY_TOP;
					end else begin
						nd = DUMMY_FAST;
					end
					next_s.tx       = {opcode, addr, 32'h0};
					next_s.hdr_bits = 7'(8 * (1 + ADDR_BYTES)) + {1'b0, nd, 3'h0};
					next_s.cs_b     = 1'b0;
					next_s.div      = 3'h0;
					next_s.bitc     = 3'h0;
					next_s.st       = HS_XFER;
				end
			end
			HS_XFER: begin
				// Fixed divider keeps link clock under read limit
				next_s.div = s.div + 3'h1;
				if (!s.sck && s.hdr_bits != 7'h0 && (s.stop_req | stop)) begin
					// Stop inside the header abandons the command
					next_s.st = HS_END;
				end else if (s.div == 3'(CLK_DIV_HALF - 1)) begin
					next_s.div = 3'h0;
					next_s.sck = ~s.sck;
					if (s.sck && s.hdr_bits != 7'h0) begin
						next_s.tx       = {s.tx[62:0], 1'b0};
						next_s.hdr_bits = s.hdr_bits - 7'h1;
					end
				end
				// Pin value at the rise reaches the far sync flop one cycle on
				if (s.sck && s.div == 3'h1 && s.hdr_bits == 7'h0) begin
					next_s.rx   = {s.rx[6:0], s.so_sync[1]};
					next_s.bitc = s.bitc + 3'h1;
					if (s.bitc == BIT_LAST) begin
						next_s.rd_data  = {s.rx[6:0], s.so_sync[1]};
						next_s.rd_valid = 1'b1;
						if (s.stop_req | stop) begin
							next_s.st = HS_END;
						end
					end
				end
			end
			HS_END: begin
				// Let a high phase run its full length before select rises
				next_s.div = s.div + 3'h1;
				if (s.div == 3'(CLK_DIV_HALF - 1)) begin
					next_s.div  = 3'h0;
					next_s.sck  = 1'b0;
					next_s.cs_b = 1'b1;
					next_s.st   = HS_IDLE;
				end
			end
			default: begin
				next_s.st = HS_IDLE;
			end
		endcase
		if (!rst_b) begin
			next_s      = '0;
			next_s.st   = HS_IDLE;
			next_s.cs_b = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		s <= next_s;
	end

	// Select stays low until stop is seen at a byte boundary, or while the link clock is low inside the header
	assign link.cs_b = s.cs_b;
	assign link.sck  = s.sck;
	assign link.si   = s.tx[63];
	assign busy      = (s.st != HS_IDLE);
	assign rd_data   = s.rd_data;
	assign rd_valid  = s.rd_valid;
endmodule : sfcr_host

/* File: verif/sfcr_link_monitor.sv */
// Link checks for the continuous read: framing, link clock and output release
`timescale 1ns/100ps
module sfcr_link_monitor (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic cs_b,
	input wire logic sck,
	input wire logic si,
	input wire logic so_out,
	input wire logic so_oe
);
	logic [7:0] rises;
	logic       sck_q;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// Saturates, only the header length matters
	always_ff @(posedge core_clk) begin
		sck_q <= sck;
		if (!rst_b || cs_b)
			rises <= 8'h00;
		else if (sck && !sck_q && rises != 8'hff)
			rises <= rises + 8'h01;
	end
	a_output_release: assert property ($rose(cs_b) |-> ##[1:6] !so_oe)
		else $error("output still driven after select rose");
	a_idle_no_drive: assert property (cs_b [*6] |-> !so_oe)
		else $error("output driven while deselected");
	a_oe_after_header: assert property ($rose(so_oe) |->
		rises == 8'h28 || rises == 8'h30 || rises == 8'h40)
		else $error("output enabled at wrong bit count");
	a_shift_on_fall: assert property (so_oe && $past(so_oe) && $changed(so_out) |-> !sck)
		else $error("output changed while link clock high");
	a_si_hold_high: assert property (sck && !cs_b |-> $stable(si))
		else $error("input data changed while link clock high");
	a_sck_half_period: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
		else $error("link clock high phase not four cycles");
	a_sck_in_frame: assert property (sck |-> !cs_b)
		else $error("link clock high outside a frame");
	a_frame_lead: assert property ($fell(cs_b) |-> !sck [*2])
		else $error("link clock rose too soon after select fell");
	a_data_stands: assert property (so_oe && !cs_b |=> so_oe)
		else $error("output released inside a frame");
endmodule : sfcr_link_monitor

/* File: verif/serial_flash_continuous_read_tb.sv */
// Bench: host and device back to back over the serial link
`timescale 1ns/100ps
module serial_flash_continuous_read_tb;
	import sfcr_pkg::*;
	logic        core_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        page_512 = 1'b0;
	logic        start = 1'b0;
	logic        stop = 1'b0;
	logic [7:0]  opcode = 8'h00;
	logic [23:0] addr = 24'h000000;
	logic [7:0]  mem_rdata;
	logic [22:0] mem_addr;
	logic        dev_busy;
	logic        host_busy;
	logic        sck_q = 1'b0;
	logic [7:0]  sh = 8'h00;
	logic [7:0]  host_rd_data;
	logic        host_rd_valid;
	int          oe_cnt = 0;
	int          last_oe = 0;
	int          n_mismatch = 0;
	int          n_compared = 0;
	int          bit_cnt = 0;
	int          hdr = 40;
	logic [7:0]  got[$];
	logic [7:0]  hgot[$];
	sfcr_link_if link ();
	sfcr_device u_sfcr_device (.core_clk(core_clk), .rst_b(rst_b), .link(link),
		.page_512(page_512), .mem_rdata(mem_rdata), .mem_addr(mem_addr), .busy(dev_busy));
	sfcr_host u_sfcr_host (.core_clk(core_clk), .rst_b(rst_b), .link(link), .start(start),
		.opcode(opcode), .addr(addr), .stop(stop), .busy(host_busy),
		.rd_data(host_rd_data), .rd_valid(host_rd_valid));
	sfcr_link_monitor u_sfcr_link_monitor (.core_clk(core_clk), .rst_b(rst_b),
		.cs_b(link.cs_b), .sck(link.sck), .si(link.si), .so_out(link.so_out), .so_oe(link.so_oe));
	always #5 core_clk = ~core_clk;
	function automatic logic [7:0] pat(input logic [22:0] a);
		return a[7:0] ^ a[15:8] ^ {1'b0, a[22:16]};
	endfunction : pat
	assign mem_rdata = pat(mem_addr);
	function automatic logic [22:0] nxt(input logic [22:0] a);
		logic [12:0] pg;
		logic [9:0]  cl;
		pg = page_512 ? a[21:9] : a[22:10];
		cl = page_512 ? {1'b0, a[8:0]} : a[9:0];
		if (cl == (page_512 ? PAGE_LAST_512 : PAGE_LAST_528)) begin
			pg = pg + 13'h0001;
			cl = 10'h000;
		end else
			cl = cl + 10'h001;
		return page_512 ? {1'b0, pg, cl[8:0]} : {pg, cl};
	endfunction : nxt
	// Wire view: data bits are taken at link clock rises after the header
	always @(posedge core_clk) begin
		sck_q <= link.sck;
		if (link.so_oe === 1'b1)
			oe_cnt <= oe_cnt + 1;
		if (host_rd_valid === 1'b1)
			hgot.push_back(host_rd_data);
		if (link.cs_b !== 1'b0)
			bit_cnt <= 0;
		else if (link.sck === 1'b1 && sck_q === 1'b0) begin
			bit_cnt <= bit_cnt + 1;
			if (bit_cnt >= hdr) begin
				sh <= {sh[6:0], link.so};
				if ((bit_cnt - hdr) % 8 == 7)
					got.push_back({sh[6:0], link.so});
			end
		end
	end
	task automatic tick();
		@(posedge core_clk);
		#1;
	endtask : tick
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic run_read(input logic p5, input logic [7:0] opc, input int dum,
		input logic [23:0] a, input int nb);
		logic [22:0] m;
		int          w;
		int          g0;
		int          h0;
		int          o0;
		g0 = got.size();
		h0 = hgot.size();
		o0 = oe_cnt;
		page_512 = p5;
		hdr = 32 + 8 * dum;
		opcode = opc;
		addr = a;
		start = 1'b1;
		tick();
		start = 1'b0;
		w = 0;
		while (got.size() <= g0 + nb && w < 5000) begin
			tick();
			w++;
		end
		check("stream length", got.size() > g0 + nb, 1'b1);
		stop = 1'b1;
		tick();
		stop = 1'b0;
		w = 0;
		while ((host_busy !== 1'b0 || dev_busy !== 1'b0) && w < 500) begin
			tick();
			w++;
		end
		last_oe = oe_cnt - o0;
		check("idle after stop", {host_busy, dev_busy, link.so_oe}, 3'h0);
		m = p5 ? {1'b0, a[21:0]} : a[22:0];
		for (int i = 0; i < nb; i++) begin
			check("stream byte", got[g0 + i], pat(m));
			check("host byte", hgot[h0 + i], pat(m));
			m = nxt(m);
		end
	endtask : run_read
	task automatic t_opcodes();
		run_read(1'b0, OPC_LEGACY, DUMMY_LEGACY, 24'h001405, 3);
		run_read(1'b0, OPC_TOP, DUMMY_TOP, 24'h001405, 3);
		run_read(1'b0, OPC_FAST, DUMMY_FAST, 24'h001405, 3);
	endtask : t_opcodes
	task automatic t_page_cross();
		run_read(1'b0, OPC_TOP, DUMMY_TOP, {1'b0, 13'h0005, 10'h20e}, 4);
		run_read(1'b1, OPC_FAST, DUMMY_FAST, {2'h0, 13'h0007, 9'h1fe}, 4);
	endtask : t_page_cross
	task automatic t_array_wrap();
		run_read(1'b0, OPC_LEGACY, DUMMY_LEGACY, {1'b0, 13'h1fff, 10'h20f}, 3);
		run_read(1'b1, OPC_TOP, DUMMY_TOP, {2'h0, 13'h1fff, 9'h1ff}, 3);
	endtask : t_array_wrap
	task automatic t_refused();
		run_read(1'b0, 8'h03, 1, 24'h000000, 0);
		check("output drive", last_oe, 0);
	endtask : t_refused
	// Select rises inside the address phase; the next read must still work
	task automatic t_abort();
		int o0;
		int w;
		o0 = oe_cnt;
		page_512 = 1'b0;
		hdr = 40;
		opcode = OPC_FAST;
		addr = 24'h001405;
		start = 1'b1;
		tick();
		start = 1'b0;
		repeat (100) tick();
		check("busy in address phase", {host_busy, dev_busy}, 2'h3);
		stop = 1'b1;
		tick();
		stop = 1'b0;
		w = 0;
		while ((host_busy !== 1'b0 || dev_busy !== 1'b0) && w < 100) begin
			tick();
			w++;
		end
		check("abandoned to idle", {host_busy, dev_busy, link.so_oe}, 3'h0);
		check("drive on abandon", oe_cnt - o0, 0);
	endtask : t_abort
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run
	initial begin
		repeat (10) tick();
		rst_b = 1'b1;
		repeat (3) tick();
		t_opcodes();
		t_page_cross();
		t_refused();
		t_abort();
		t_array_wrap();
		complete_run();
	end
	// Reads take well under 100 us
	initial begin
		#400000;
		n_mismatch++;
		complete_run();
	end
endmodule : serial_flash_continuous_read_tb
